// [design/pnsg_top.sv]
`timescale 1ns/1ps
`include "pnsg_defines.svh"

// Notes on behaviour
// - data generators step at oscillator over two, except low one while its buffer is full
// - oscillators run at twice the data rate
// - low-rate generator: 10-bit maximal LFSR
// - high-rate generator: 13-bit maximal LFSR
// - one shared reset zeroes both data generators
// - spreading generator: 11-bit, taps 9 and 11
// - separate reset initialises the spreading register
// - data channels spread by chips continuously
// - single-channel mode takes over low-rate path
module pnsg_top
    import pnsg_pkg::*;
#(
    parameter int LO_WIDTH   = `PNSG_LO_WIDTH,
    parameter int HI_WIDTH   = `PNSG_HI_WIDTH,
    parameter int CODE_WIDTH = `PNSG_CODE_WIDTH,
    parameter int BUF_DEPTH  = `PNSG_BUF_DEPTH
) (
    // clock and reset
    input  wire logic CLK_I,
    input  wire logic RST_B_I,
    // oscillator pins
    input  wire logic OSC_LO_I,
    input  wire logic OSC_HI_I,
    input  wire logic OSC_SINGLE_I,
    // chip clock pin
    input  wire logic CHIP_CLK_I,
    // operator switches
    input  wire logic DATA_RST_I,
    input  wire logic CODE_RST_I,
    input  wire logic SINGLE_MODE_I,
    // data and chip streams
    output logic      LO_DATA_O,
    output logic      HI_DATA_O,
    output logic      CHIP_O,
    output logic      LO_SPREAD_O,
    output logic      HI_SPREAD_O,
    // registered divided-clock data-rate references
    output logic      LO_REF_CLK_O,
    output logic      HI_REF_CLK_O,
    // word-start markers
    output logic      LO_EPOCH_O,
    output logic      HI_EPOCH_O,
    output logic      CODE_EPOCH_O,
    // status
    output logic      SINGLE_ACTIVE_O,
    output logic      CHIP_ACTIVE_O,
    output logic      LO_SLIP_O,
    // low-path stream
    output logic      LO_VALID_O,
    input  wire logic LO_READY_I,
    output logic      LO_BIT_O
);

    localparam int PIN_N = 7;
    localparam int QUIET_W = 8;
    localparam logic [QUIET_W-1:0] QUIET_CYC = QUIET_W'(`PNSG_CHIP_QUIET_CYC);

    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_meta;
    logic [PIN_N-1:0] pin_sync;
    logic [3:0]       clk_last;
    logic             osc_lo_s;
    logic             osc_hi_s;
    logic             osc_single_s;
    logic             chip_clk_s;
    logic             data_rst_s;
    logic             code_rst_s;
    logic             single_s;
    pnsg_mode_t       mode;
    logic             lo_osc_rise;
    logic             hi_osc_rise;
    logic             chip_rise;
    logic             lo_div;
    logic             hi_div;
    logic             lo_tick;
    logic             hi_tick;
    logic             lo_step;
    logic [LO_WIDTH-1:0]   lo_state;
    logic [HI_WIDTH-1:0]   hi_state;
    logic [CODE_WIDTH-1:0] code_state;
    logic                  lo_bit;
    logic                  hi_bit;
    logic                  chip_bit;
    pnsg_code_state_t      code_fsm;
    pnsg_code_state_t      next_code_fsm;
    logic [QUIET_W-1:0]    quiet_cnt;
    logic                  buf_in_ready;
    logic                  buf_out_valid;
    logic                  buf_out_data;

    function automatic logic rise(input logic now, input logic last);
        return now && !last;
    endfunction

    assign pin_raw = {SINGLE_MODE_I, CODE_RST_I, DATA_RST_I,
                      CHIP_CLK_I, OSC_SINGLE_I, OSC_HI_I, OSC_LO_I};

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    assign osc_lo_s     = pin_sync[0];
    assign osc_hi_s     = pin_sync[1];
    assign osc_single_s = pin_sync[2];
    assign chip_clk_s   = pin_sync[3];
    assign data_rst_s   = pin_sync[4];
    assign code_rst_s   = pin_sync[5];
    assign single_s     = pin_sync[6];

    // previous levels of the clock-like pins for edge detection
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            clk_last <= '0;
        end else begin
            clk_last <= pin_sync[3:0];
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            mode            <= PNSG_MODE_DUAL;
            SINGLE_ACTIVE_O <= 1'b0;
        end else begin
            mode            <= single_s ? PNSG_MODE_SINGLE : PNSG_MODE_DUAL;
            SINGLE_ACTIVE_O <= (mode == PNSG_MODE_SINGLE);
        end
    end

    // low path is clocked by the single-channel oscillator in that mode
    assign lo_osc_rise = (mode == PNSG_MODE_SINGLE)
                       ? rise(osc_single_s, clk_last[2])
                       : rise(osc_lo_s, clk_last[0]);
    assign hi_osc_rise = rise(osc_hi_s, clk_last[1]);
    assign chip_rise   = rise(chip_clk_s, clk_last[3]);

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            lo_div <= 1'b0;
        end else if (data_rst_s) begin
            lo_div <= 1'b0;
        end else if (lo_osc_rise) begin
            lo_div <= !lo_div;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            hi_div <= 1'b0;
        end else if (data_rst_s) begin
            hi_div <= 1'b0;
        end else if (hi_osc_rise) begin
            hi_div <= !hi_div;
        end
    end

    assign lo_tick = lo_osc_rise && lo_div;
    assign hi_tick = hi_osc_rise && hi_div;
    // a full buffer holds the low generator back
    assign lo_step = lo_tick && buf_in_ready;

    // divided clock goes out as the data-rate reference
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            LO_REF_CLK_O <= 1'b0;
            HI_REF_CLK_O <= 1'b0;
        end else begin
            LO_REF_CLK_O <= lo_div;
            HI_REF_CLK_O <= hi_div;
        end
    end

    pnsg_lfsr #(
        .WIDTH (LO_WIDTH),
        .TAPS  (LO_WIDTH'(`PNSG_LO_TAPS))
    ) u_lo_gen (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .load_i  (data_rst_s),
        .step_i  (lo_step),
        .state_o (lo_state)
    );

    pnsg_lfsr #(
        .WIDTH (HI_WIDTH),
        .TAPS  (HI_WIDTH'(`PNSG_HI_TAPS))
    ) u_hi_gen (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .load_i  (data_rst_s),
        .step_i  (hi_tick),
        .state_o (hi_state)
    );

    pnsg_lfsr #(
        .WIDTH (CODE_WIDTH),
        .TAPS  (CODE_WIDTH'(`PNSG_CODE_TAPS))
    ) u_code_gen (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .load_i  (code_rst_s),
        .step_i  (chip_rise && !code_rst_s),
        .state_o (code_state)
    );

    assign lo_bit   = lo_state[LO_WIDTH-1];
    assign hi_bit   = hi_state[HI_WIDTH-1];
    assign chip_bit = code_state[CODE_WIDTH-1];

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            LO_DATA_O <= 1'b0;
            HI_DATA_O <= 1'b0;
            CHIP_O    <= 1'b0;
        end else begin
            LO_DATA_O <= lo_bit;
            HI_DATA_O <= hi_bit;
            CHIP_O    <= chip_bit;
        end
    end

    // both data channels spread by the running chip stream
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            LO_SPREAD_O <= 1'b0;
            HI_SPREAD_O <= 1'b0;
        end else begin
            LO_SPREAD_O <= lo_bit ^ chip_bit;
            HI_SPREAD_O <= hi_bit ^ chip_bit;
        end
    end

    // one-cycle pulse when a generator passes through its start state
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            LO_EPOCH_O   <= 1'b0;
            HI_EPOCH_O   <= 1'b0;
            CODE_EPOCH_O <= 1'b0;
        end else begin
            LO_EPOCH_O   <= lo_step && (lo_state == '0);
            HI_EPOCH_O   <= hi_tick && (hi_state == '0);
            CODE_EPOCH_O <= chip_rise && !code_rst_s
                            && (code_state == '0);
        end
    end

    // sticky slip flag: a low-path step lost to a full buffer
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            LO_SLIP_O <= 1'b0;
        end else if (lo_tick && !buf_in_ready) begin
            LO_SLIP_O <= 1'b1;
        end else if (data_rst_s) begin
            LO_SLIP_O <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            quiet_cnt <= '0;
        end else if (chip_rise) begin
            quiet_cnt <= QUIET_CYC;
        end else if (quiet_cnt != '0) begin
            quiet_cnt <= quiet_cnt - 1'b1;
        end
    end

    always_comb begin
        next_code_fsm = code_fsm;
        case (code_fsm)
            PNSG_CODE_HELD: begin
                if (!code_rst_s) begin
                    next_code_fsm = PNSG_CODE_IDLE;
                end
            end
            PNSG_CODE_IDLE: begin
                if (code_rst_s) begin
                    next_code_fsm = PNSG_CODE_HELD;
                end else if (chip_rise) begin
                    next_code_fsm = PNSG_CODE_RUN;
                end
            end
            PNSG_CODE_RUN: begin
                if (code_rst_s) begin
                    next_code_fsm = PNSG_CODE_HELD;
                end else if (quiet_cnt == '0) begin
                    next_code_fsm = PNSG_CODE_IDLE;
                end
            end
            default: begin
                next_code_fsm = PNSG_CODE_HELD;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            code_fsm <= PNSG_CODE_HELD;
        end else begin
            code_fsm <= next_code_fsm;
        end
    end

    assign CHIP_ACTIVE_O = (code_fsm == PNSG_CODE_RUN);

    pnsg_buf #(
        .WIDTH (1),
        .DEPTH (BUF_DEPTH)
    ) u_lo_buf (
        .clk_i       (CLK_I),
        .rst_b_i     (RST_B_I),
        .flush_i     (data_rst_s),
        .in_valid_i  (lo_tick),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (lo_bit),
        .out_valid_o (buf_out_valid),
        .out_ready_i (LO_READY_I),
        .out_data_o  (buf_out_data)
    );

    assign LO_VALID_O = buf_out_valid;
    assign LO_BIT_O   = buf_out_data;

endmodule // pnsg_top

// [inc/pnsg_defines.svh]
`ifndef PNSG_DEFINES_SVH
`define PNSG_DEFINES_SVH

// system clock
`define PNSG_CLK_PERIOD_NS   100

// nominal oscillator and chip rates, in kHz
`define PNSG_OSC_LO_KHZ      144
`define PNSG_OSC_HI_KHZ      6000
`define PNSG_CHIP_KHZ        14100
`define PNSG_SINGLE_KBPS     216

// generator lengths
`define PNSG_LO_WIDTH        10
`define PNSG_HI_WIDTH        13
`define PNSG_CODE_WIDTH      11

// feedback tap masks, bit n-1 stands for stage n
`define PNSG_LO_TAPS         10'h240
`define PNSG_HI_TAPS         13'h100d
`define PNSG_CODE_TAPS       11'h500

// all generators load the all-zero state
`define PNSG_SEED_ZERO       1'b0

// chip clock counts as stopped after this quiet time
`define PNSG_CHIP_QUIET_NS   1000
`define PNSG_CHIP_QUIET_CYC  ((`PNSG_CHIP_QUIET_NS) / (`PNSG_CLK_PERIOD_NS))

// low-path stream buffer depth
`define PNSG_BUF_DEPTH       2

`endif

// [inc/pnsg_pkg.sv]
package pnsg_pkg;

    typedef enum logic {
        PNSG_MODE_DUAL,
        PNSG_MODE_SINGLE
    } pnsg_mode_t;

    typedef enum logic [1:0] {
        PNSG_CODE_HELD,
        PNSG_CODE_IDLE,
        PNSG_CODE_RUN
    } pnsg_code_state_t;

endpackage

// [design/pnsg_lfsr.sv]
`timescale 1ns/1ps
`include "pnsg_defines.svh"
module pnsg_lfsr #(
    parameter int          WIDTH = 10,
    parameter logic [WIDTH-1:0] TAPS = '0
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // control
    input  wire logic             load_i,
    input  wire logic             step_i,
    // state
    output logic [WIDTH-1:0]      state_o
);

    logic fb;

    // xnor keeps all-zero inside the maximal sequence
    assign fb = ~(^(state_o & TAPS));

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_o <= '0;
        end else if (load_i) begin
            state_o <= {WIDTH{`PNSG_SEED_ZERO}};
        end else if (step_i) begin
            state_o <= {state_o[WIDTH-2:0], fb};
        end
    end

endmodule // pnsg_lfsr

// [design/pnsg_buf.sv]
`timescale 1ns/1ps
module pnsg_buf #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             flush_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    // an empty buffer shows zero, never stale or unset storage
    assign out_data_o  = out_valid_o ? mem[rd_ptr] : '0;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= nxt(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= nxt(rd_ptr);
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule // pnsg_buf

// [test/pnsg_monitor.sv]
`timescale 1ns/1ps
module pnsg_monitor (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // pins
    input wire logic CHIP_CLK_I,
    input wire logic DATA_RST_I,
    input wire logic CODE_RST_I,
    input wire logic SINGLE_MODE_I,
    input wire logic LO_READY_I,
    // streams and status
    input wire logic LO_DATA_O,
    input wire logic HI_DATA_O,
    input wire logic CHIP_O,
    input wire logic LO_SPREAD_O,
    input wire logic HI_SPREAD_O,
    input wire logic CODE_EPOCH_O,
    input wire logic SINGLE_ACTIVE_O,
    input wire logic CHIP_ACTIVE_O,
    input wire logic LO_SLIP_O,
    input wire logic LO_VALID_O,
    input wire logic LO_BIT_O
);
    logic [2:0] drst_h;
    logic       calm;

    default clocking mon_cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    // data reset history, spans the synchroniser delay
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I)
            drst_h <= 3'h0;
        else
            drst_h <= {drst_h[1:0], DATA_RST_I};
    end
    assign calm = !DATA_RST_I && (drst_h == 3'h0);

    a_data_rst_zero: assert property (DATA_RST_I [*5] |=>
        !LO_DATA_O && !HI_DATA_O) else $error("data not zeroed");
    a_code_rst_zero: assert property (CODE_RST_I [*5] |=>
        !CHIP_O && !CHIP_ACTIVE_O) else $error("code not zeroed");
    a_chip_quiet: assert property ((!CHIP_CLK_I) [*8] ##1
        (!CHIP_CLK_I) [*8] |-> !CHIP_ACTIVE_O) else $error("active stuck");
    a_lo_spread_xor: assert property (
        ($stable(LO_DATA_O) && $stable(CHIP_O)) ##1
        ($stable(LO_DATA_O) && $stable(CHIP_O)) |->
        LO_SPREAD_O == (LO_DATA_O ^ CHIP_O)) else $error("low spread");
    a_hi_spread_xor: assert property (
        ($stable(HI_DATA_O) && $stable(CHIP_O)) ##1
        ($stable(HI_DATA_O) && $stable(CHIP_O)) |->
        HI_SPREAD_O == (HI_DATA_O ^ CHIP_O)) else $error("high spread");
    a_slip_sticky: assert property (LO_SLIP_O && calm |=>
        LO_SLIP_O) else $error("slip flag dropped");
    a_buf_hold_word: assert property (
        LO_VALID_O && !LO_READY_I && calm |=>
        LO_VALID_O && $stable(LO_BIT_O)) else $error("stalled word lost");
    a_single_on: assert property (SINGLE_MODE_I [*4] |=>
        SINGLE_ACTIVE_O) else $error("single mode not shown");
    a_code_epoch_pulse: assert property (CODE_EPOCH_O |=>
        !CODE_EPOCH_O) else $error("code epoch too long");
endmodule // pnsg_monitor

bind pnsg_top pnsg_monitor mon_u (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .CHIP_CLK_I(CHIP_CLK_I),
    .DATA_RST_I(DATA_RST_I), .CODE_RST_I(CODE_RST_I),
    .SINGLE_MODE_I(SINGLE_MODE_I), .LO_READY_I(LO_READY_I),
    .LO_DATA_O(LO_DATA_O), .HI_DATA_O(HI_DATA_O), .CHIP_O(CHIP_O),
    .LO_SPREAD_O(LO_SPREAD_O), .HI_SPREAD_O(HI_SPREAD_O),
    .CODE_EPOCH_O(CODE_EPOCH_O), .SINGLE_ACTIVE_O(SINGLE_ACTIVE_O),
    .CHIP_ACTIVE_O(CHIP_ACTIVE_O), .LO_SLIP_O(LO_SLIP_O),
    .LO_VALID_O(LO_VALID_O), .LO_BIT_O(LO_BIT_O)
);

// [test/pnsg_mod_model.sv]
`timescale 1ns/1ps
module pnsg_mod_model (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // bench control
    input  wire logic run_i,
    input  wire logic stall_i,
    // toward the block
    output logic      chip_clk_o,
    output logic      ready_o
);
    logic [2:0] phase;

    // chip clock three cycles high, three low, still between frames
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase      <= 3'h0;
            chip_clk_o <= 1'b0;
        end else if (run_i || phase != 3'h0) begin
            phase      <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
            chip_clk_o <= (phase < 3'h3);
        end
    end

    // consumer answers one cycle after the bench asks it to stall
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            ready_o <= 1'b0;
        else
            ready_o <= !stall_i;
    end
endmodule // pnsg_mod_model

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench
    import pnsg_pkg::*;
;
    typedef struct {
        int         pin;
        pnsg_mode_t mode;
        int         pairs;
        logic       lo_mv;
        logic       hi_mv;
    } pnsg_row_t;

    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        osc_lo = 1'b0;
    logic        osc_hi = 1'b0;
    logic        osc_sg = 1'b0;
    logic        d_rst = 1'b0;
    logic        c_rst = 1'b0;
    logic        sg_mode = 1'b0;
    logic        run = 1'b0;
    logic        stall = 1'b0;
    logic        chip_clk, ready, lo_d, hi_d, chip, lo_sp, hi_sp, lo_ref;
    logic        hi_ref, lo_ep, hi_ep, c_ep, sg_act, c_act, slip, lo_v, lo_b;
    logic [9:0]  m_lo = 10'h000;
    logic [12:0] m_hi = 13'h0000;
    logic [10:0] m_ch = 11'h000;
    logic [1:0]  q;
    logic        ref0;
    int          n_errors = 0;
    int          checks_done = 0;
    int          n_lo_ep = 0;
    int          n_c_ep = 0;
    int          n_hi_ep = 0;
    int          n_chips = 0;
    int          base;
    pnsg_row_t   rows [6] = '{
        '{0, PNSG_MODE_DUAL, 12, 1'b1, 1'b0},
        '{1, PNSG_MODE_DUAL, 16, 1'b0, 1'b1},
        '{2, PNSG_MODE_DUAL, 3, 1'b0, 1'b0},
        '{2, PNSG_MODE_SINGLE, 12, 1'b1, 1'b0},
        '{0, PNSG_MODE_SINGLE, 3, 1'b0, 1'b0},
        '{1, PNSG_MODE_SINGLE, 5, 1'b0, 1'b1}
    };

    always #50 clk = ~clk;

    pnsg_mod_model model_u (
        .clk_i(clk), .rst_b_i(rst_b), .run_i(run), .stall_i(stall),
        .chip_clk_o(chip_clk), .ready_o(ready)
    );

    pnsg_top dut_u (
        .CLK_I(clk), .RST_B_I(rst_b), .OSC_LO_I(osc_lo), .OSC_HI_I(osc_hi),
        .OSC_SINGLE_I(osc_sg), .CHIP_CLK_I(chip_clk), .DATA_RST_I(d_rst),
        .CODE_RST_I(c_rst), .SINGLE_MODE_I(sg_mode), .LO_DATA_O(lo_d),
        .HI_DATA_O(hi_d), .CHIP_O(chip), .LO_SPREAD_O(lo_sp),
        .HI_SPREAD_O(hi_sp), .LO_REF_CLK_O(lo_ref), .HI_REF_CLK_O(hi_ref),
        .LO_EPOCH_O(lo_ep), .HI_EPOCH_O(hi_ep), .CODE_EPOCH_O(c_ep),
        .SINGLE_ACTIVE_O(sg_act), .CHIP_ACTIVE_O(c_act), .LO_SLIP_O(slip),
        .LO_VALID_O(lo_v), .LO_READY_I(ready), .LO_BIT_O(lo_b)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic all_zero;
        chk({lo_d, hi_d, chip, lo_sp, hi_sp, lo_ref, hi_ref, lo_ep, hi_ep,
             c_ep, sg_act, c_act, slip, lo_v, lo_b}, 16'h0000);
    endtask

    task automatic pulse(input int pin);
        osc_lo = (pin == 0);
        osc_hi = (pin == 1);
        osc_sg = (pin == 2);
        tick(2);
        osc_lo = 1'b0;
        osc_hi = 1'b0;
        osc_sg = 1'b0;
        tick(2);
    endtask

    // one data step takes two oscillator rises
    task automatic steps(input int pin, input int n, input logic lm,
                         input logic hm);
        repeat (n) begin
            pulse(pin);
            pulse(pin);
            tick(3);
            if (lm)
                m_lo = {m_lo[8:0], ~^{m_lo[9], m_lo[6]}};
            if (hm)
                m_hi = {m_hi[11:0], ~^{m_hi[12], m_hi[3], m_hi[2], m_hi[0]}};
            chk(lo_d, m_lo[9]);
            chk(hi_d, m_hi[12]);
        end
    endtask

    always @(posedge clk) begin
        if (lo_ep === 1'b1)
            n_lo_ep++;
        if (c_ep === 1'b1)
            n_c_ep++;
        if (hi_ep === 1'b1)
            n_hi_ep++;
    end

    always @(posedge chip_clk) begin
        chk(chip, m_ch[10]);
        m_ch = {m_ch[9:0], ~^{m_ch[10], m_ch[8]}};
        n_chips++;
    end

    initial begin
        tick(10);
        all_zero();
        tick(6);
        rst_b = 1'b1;
        tick(4);
        foreach (rows[i]) begin
            sg_mode = (rows[i].mode == PNSG_MODE_SINGLE);
            tick(4);
            chk(sg_act, rows[i].mode);
            steps(rows[i].pin, rows[i].pairs, rows[i].lo_mv, rows[i].hi_mv);
        end
        sg_mode = 1'b0;
        // stalled consumer: two words held, third step refused
        stall = 1'b1;
        tick(2);
        q[0] = m_lo[9];
        steps(0, 1, 1'b1, 1'b0);
        q[1] = m_lo[9];
        steps(0, 1, 1'b1, 1'b0);
        pulse(0);
        pulse(0);
        tick(3);
        chk({lo_v, slip, lo_b, lo_d}, {1'b1, 1'b1, q[0], m_lo[9]});
        stall = 1'b0;
        tick(1);
        stall = 1'b1;
        tick(3);
        chk({lo_v, lo_b}, {1'b1, q[1]});
        stall = 1'b0;
        tick(3);
        chk({lo_v, slip}, 2'b01);
        d_rst = 1'b1;
        tick(6);
        d_rst = 1'b0;
        tick(4);
        m_lo = 10'h000;
        m_hi = 13'h0000;
        chk({lo_d, hi_d, lo_v, slip}, 4'h0);
        base = n_lo_ep;
        steps(0, 1, 1'b1, 1'b0);
        chk(16'(n_lo_ep - base), 16'h0001);
        steps(0, 1022, 1'b1, 1'b0);
        chk(16'(n_lo_ep - base), 16'h0001);
        steps(0, 1, 1'b1, 1'b0);
        chk(16'(n_lo_ep - base), 16'h0002);
        steps(1, 20, 1'b0, 1'b1);
        chk(16'(n_hi_ep), 16'h0002);
        c_rst = 1'b1;
        tick(6);
        c_rst = 1'b0;
        tick(4);
        chk({chip, c_act, hi_d}, {2'b00, m_hi[12]});
        base = n_c_ep;
        run = 1'b1;
        for (int i = 0; i < 20000 && n_chips < 2048; i++)
            tick(1);
        if (n_chips < 2048) begin
            n_errors++;
            report_and_stop();
        end
        chk({16'(n_c_ep - base)}, 16'h0001);
        chk(c_act, 1'b1);
        run = 1'b0;
        tick(20);
        chk(16'(n_c_ep - base), 16'h0002);
        chk({c_act, lo_sp, hi_sp}, {1'b0, lo_d ^ chip, hi_d ^ chip});
        ref0 = lo_ref;
        pulse(0);
        tick(2);
        chk(lo_ref, !ref0);
        ref0 = hi_ref;
        pulse(1);
        tick(2);
        chk(hi_ref, !ref0);
        rst_b = 1'b0;
        tick(2);
        all_zero();
        rst_b = 1'b1;
        tick(3);
        all_zero();
        report_and_stop();
    end
endmodule // testbench
